// ---- rtl/timer_start_lockstep_ctrl.sv ----
`timescale 1ns/10ps
// Contract
// R1 - Run register: bit n lets channel n count; all zero after reset.
// R2 - Run and lockstep registers are 8 bits, processor readable and writable.
// R3 - Run register becomes e0 on reset and on standby entry.
// R4 - Bits 7 to 5 of both registers read one; writes ignored.
// R5 - Lockstep register becomes e0 on reset and on standby entry.
// R6 - Lockstep register: bit n selects lockstep for channel n.
// R7 - Independent channel preset or clear touches only that channel.
// R8 - Lockstep channel joins shared preset and clear of all lockstep channels.
// R9 - Write or clear on one lockstep counter hits all lockstep counters together.
module timer_start_lockstep_ctrl
  import timer_start_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              standby,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [REG_W-1:0]  wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  input  wire logic [NUM_CH-1:0] clear_event,
  output logic      [REG_W-1:0]  rdata,
  output logic      [NUM_CH-1:0] run_out,
  output logic      [NUM_CH-1:0] lockstep_out
);
  // ==========================================================
  // Registers
  logic [NUM_CH-1:0] run_r;
  logic [NUM_CH-1:0] lock_r;
  logic [CNT_W-1:0]  preset_val_r;
  logic [2:0]        count_sel_r;
  logic [REG_W-1:0]  rdata_r;
  logic [REG_W-1:0]  rdata_nxt;
  // ==========================================================
  // Decode and request nets
  logic              hit_run;
  logic              hit_lock;
  logic              hit_pval;
  logic              hit_pcmd;
  logic              hit_ccmd;
  logic              hit_sel;
  logic              hit_lo;
  logic              hit_hi;
  logic              wr_run;
  logic              wr_lock;
  logic              wr_pval;
  logic              wr_pcmd;
  logic              wr_ccmd;
  logic              wr_sel;
  logic [NUM_CH-1:0] preset_req;
  logic [NUM_CH-1:0] clear_req;
  logic              preset_hit;
  logic              clear_hit;
  logic [NUM_CH-1:0] preset_fan;
  logic [NUM_CH-1:0] clear_fan;
  logic [CNT_W-1:0]  sel_count;

  counter_bank_if cb ();

  // ==========================================================
  // Address decode, shared by the write and read paths
  always_comb
  begin
    hit_run  = 1'b0;
    hit_lock = 1'b0;
    hit_pval = 1'b0;
    hit_pcmd = 1'b0;
    hit_ccmd = 1'b0;
    hit_sel  = 1'b0;
    hit_lo   = 1'b0;
    hit_hi   = 1'b0;
    if (addr == RUN_CTRL_OFFSET)
      hit_run = 1'b1;
    else if (addr == LOCKSTEP_OFFSET)
      hit_lock = 1'b1;
    else if (addr == PRESET_VAL_OFF)
      hit_pval = 1'b1;
    else if (addr == PRESET_CMD_OFF)
      hit_pcmd = 1'b1;
    else if (addr == CLEAR_CMD_OFF)
      hit_ccmd = 1'b1;
    else if (addr == COUNT_SEL_OFF)
      hit_sel = 1'b1;
    else if (addr == COUNT_LO_OFF)
      hit_lo = 1'b1;
    else if (addr == COUNT_HI_OFF)
      hit_hi = 1'b1;
  end

  // Write strobes, one per register except the count readback pair; their writes and unmapped writes fall through
  assign wr_run  = wr_stb & hit_run;
  assign wr_lock = wr_stb & hit_lock;
  assign wr_pval = wr_stb & hit_pval;
  assign wr_pcmd = wr_stb & hit_pcmd;
  assign wr_ccmd = wr_stb & hit_ccmd;
  assign wr_sel  = wr_stb & hit_sel;

  // Preset and clear requests before lockstep fan-out
  always_comb
  begin
    preset_req = '0;
    clear_req  = clear_event;
    if (wr_pcmd)
      preset_req = wdata[NUM_CH-1:0];
    if (wr_ccmd)
      clear_req = clear_event | wdata[NUM_CH-1:0];
  end

  // ==========================================================
  // Control registers
  // Run register, reset and standby force e0
  always_ff @(posedge mclk)
  begin
    if (!resetn || standby)
      run_r <= RUN_CTRL_RESET[NUM_CH-1:0]; // R1 R3
    else if (wr_run)
      run_r <= wdata[NUM_CH-1:0]; // R1 R2 R4
  end

  // Lockstep register, reset and standby force e0
  always_ff @(posedge mclk)
  begin
    if (!resetn || standby)
      lock_r <= LOCKSTEP_RESET[NUM_CH-1:0]; // R5
    else if (wr_lock)
      lock_r <= wdata[NUM_CH-1:0]; // R6 R2 R4
  end

  // Preset value, each write shifts a byte in from the low end
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      preset_val_r <= COUNT_RESET;
    else if (wr_pval)
      preset_val_r <= {preset_val_r[7:0], wdata};
  end

  // Counter readback selector
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      count_sel_r <= 3'h0;
    else if (wr_sel)
      count_sel_r <= wdata[2:0];
  end

  // ==========================================================
  // Lockstep fan-out of preset and clear
  // Does any request land on a lockstep channel
  assign preset_hit = |(preset_req & lock_r);
  assign clear_hit  = |(clear_req & lock_r);

  // A lockstep channel follows any lockstep request, an independent one only its own
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_fan
      assign preset_fan[ch] = preset_req[ch] | (lock_r[ch] & preset_hit); // R7 R8 R9
      assign clear_fan[ch]  = clear_req[ch] | (lock_r[ch] & clear_hit); // R7 R8 R9
    end
  endgenerate

  // Control bundle to the counter bank
  assign cb.run        = run_r;
  assign cb.preset     = preset_fan;
  assign cb.clear      = clear_fan;
  assign cb.preset_val = preset_val_r;

  // Counter bank
  counter_bank u_bank (
    .mclk   (mclk),
    .resetn (resetn),
    .cb     (cb)
  );

  // ==========================================================
  // Read path, data one cycle after the strobe
  // Counter selected for readback, zero past the last channel
  always_comb
  begin
    if (count_sel_r < 3'(NUM_CH))
      sel_count = cb.counts[count_sel_r*CNT_W +: CNT_W];
    else
      sel_count = COUNT_RESET;
  end

  // Read mux, zero when no read is under way
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (!rd_stb)
      rdata_nxt = 8'h00;
    else if (hit_run)
      rdata_nxt = RSVD_MASK | {3'h0, run_r}; // R2 R4
    else if (hit_lock)
      rdata_nxt = RSVD_MASK | {3'h0, lock_r}; // R2 R4
    else if (hit_pval)
      rdata_nxt = preset_val_r[7:0];
    else if (hit_sel)
      rdata_nxt = {5'h00, count_sel_r};
    else if (hit_lo)
      rdata_nxt = sel_count[7:0];
    else if (hit_hi)
      rdata_nxt = sel_count[15:8];
  end

  // Read data register, stands for one cycle only
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      rdata_r <= 8'h00;
    else
      rdata_r <= rdata_nxt;
  end

  // Outputs straight from their registers
  assign rdata        = rdata_r;
  assign run_out      = run_r;
  assign lockstep_out = lock_r;
endmodule : timer_start_lockstep_ctrl

// ---- rtl/timer_start_pkg.sv ----
package timer_start_pkg;
  // ==========================================================
  // Geometry
  localparam int          NUM_CH          = 5;
  localparam int          CNT_W           = 16;
  localparam int          REG_W           = 8;
  localparam int          ADDR_W          = 4;
  // ==========================================================
  // Register offsets
  localparam logic [3:0]  RUN_CTRL_OFFSET = 4'h0;
  localparam logic [3:0]  LOCKSTEP_OFFSET = 4'h1;
  localparam logic [3:0]  PRESET_VAL_OFF  = 4'h2;
  localparam logic [3:0]  PRESET_CMD_OFF  = 4'h3;
  localparam logic [3:0]  CLEAR_CMD_OFF   = 4'h4;
  localparam logic [3:0]  COUNT_SEL_OFF   = 4'h5;
  localparam logic [3:0]  COUNT_LO_OFF    = 4'h6;
  localparam logic [3:0]  COUNT_HI_OFF    = 4'h7;
  // ==========================================================
  // Field layout and reset values
  localparam int          CH_FIELD_LSB    = 0;
  localparam int          RSVD_LSB        = 5;
  localparam logic [7:0]  RSVD_MASK       = 8'he0;
  localparam logic [7:0]  RUN_CTRL_RESET  = 8'he0;
  localparam logic [7:0]  LOCKSTEP_RESET  = 8'he0;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
endpackage : timer_start_pkg

// ---- rtl/counter_bank_if.sv ----
`timescale 1ns/10ps
// Control bundle from register front end to the counter bank
interface counter_bank_if;
  import timer_start_pkg::*;
  logic [NUM_CH-1:0] run;
  logic [NUM_CH-1:0] preset;
  logic [NUM_CH-1:0] clear;
  logic [CNT_W-1:0]  preset_val;
  logic [NUM_CH*CNT_W-1:0] counts;
  modport ctrl (output run, output preset, output clear, output preset_val, input counts);
  modport bank (input run, input preset, input clear, input preset_val, output counts);
endinterface : counter_bank_if

// ---- rtl/counter_bank.sv ----
`timescale 1ns/10ps
module counter_bank
  import timer_start_pkg::*;
(
  input  wire logic mclk,
  input  wire logic resetn,
  counter_bank_if.bank cb
);
  // ==========================================================
  // Per-channel counters
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      logic [CNT_W-1:0] cnt_r;
      // Clear beats preset, preset beats counting
      always_ff @(posedge mclk)
      begin
        if (!resetn)
          cnt_r <= COUNT_RESET;
        else if (cb.clear[g])
          cnt_r <= COUNT_RESET;
        else if (cb.preset[g])
          cnt_r <= cb.preset_val;
        else if (cb.run[g])
          cnt_r <= cnt_r + 16'h0001;
      end
      assign cb.counts[g*CNT_W +: CNT_W] = cnt_r;
    end
  endgenerate
endmodule : counter_bank

// ---- testbench/tslc_asserts.sv ----
`timescale 1ns/10ps
module tslc_asserts
  import timer_start_pkg::*;
(
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic              standby,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [REG_W-1:0]  wdata,
  input wire logic              wr_stb,
  input wire logic              rd_stb,
  input wire logic [NUM_CH-1:0] clear_event,
  input wire logic [REG_W-1:0]  rdata,
  input wire logic [NUM_CH-1:0] run_out,
  input wire logic [NUM_CH-1:0] lockstep_out
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ==========================================
  // Register relations
  rsvd_rd_a: assert property (rd_stb && addr <= LOCKSTEP_OFFSET |=> rdata[7:5] == 3'h7)
    else $error("reserved bits not one");
  run_wr_a: assert property (wr_stb && addr == RUN_CTRL_OFFSET && !standby |=> run_out == $past(wdata[4:0]))
    else $error("run write lost");
  lock_wr_a: assert property (wr_stb && addr == LOCKSTEP_OFFSET && !standby |=> lockstep_out == $past(wdata[4:0]))
    else $error("lockstep write lost");
  stby_clr_a: assert property (standby |=> run_out == 5'h00 && lockstep_out == 5'h00)
    else $error("standby did not clear");
  run_rd_a: assert property (rd_stb && addr == RUN_CTRL_OFFSET |=> rdata == {3'h7, $past(run_out)})
    else $error("run readback wrong");
  lock_rd_a: assert property (rd_stb && addr == LOCKSTEP_OFFSET |=> rdata == {3'h7, $past(lockstep_out)})
    else $error("lockstep readback wrong");
  idle_rd_a: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data outside read");
  hold_reg_a: assert property (resetn && !wr_stb && !standby |=> $stable(run_out) && $stable(lockstep_out))
    else $error("register moved without write");
  // ==========================================
  // Scenario covers
  cover property (wr_stb && addr == RUN_CTRL_OFFSET);
  cover property (standby);
  cover property (|clear_event && |lockstep_out);
endmodule : tslc_asserts
bind timer_start_lockstep_ctrl tslc_asserts tslc_asserts_i (.mclk, .resetn, .standby, .addr, .wdata,
  .wr_stb, .rd_stb, .clear_event, .rdata, .run_out, .lockstep_out);

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
module tb;
  import timer_start_pkg::*;
  typedef struct packed {logic [3:0] a; logic [7:0] d, e;} row_t;
  logic       mclk, resetn, standby, wr_stb, rd_stb;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v, h;
  logic [4:0] clear_event, run_out, lockstep_out;
  int         mismatches, cmp_count;
  row_t       rows [10] = '{'{4'h0, 8'h1f, 8'hff}, '{4'h0, 8'h03, 8'he3}, '{4'h1, 8'h15, 8'hf5},
    '{4'h1, 8'hff, 8'hff}, '{4'h1, 8'h00, 8'he0}, '{4'h0, 8'h00, 8'he0}, '{4'h8, 8'h5a, 8'h00},
    '{4'h2, 8'h56, 8'h56}, '{4'h5, 8'h07, 8'h07}, '{4'h6, 8'h00, 8'h00}};
  timer_start_lockstep_ctrl timer_start_lockstep_ctrl_i (.mclk, .resetn, .standby, .addr, .wdata,
    .wr_stb, .rd_stb, .clear_event, .rdata, .run_out, .lockstep_out);
  // ==========================================
  // Clock and watchdog
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    close_out;
  end
  // ==========================================
  // Bus and compare tasks
  task automatic chk(input logic [15:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] r);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 r = rdata;
  endtask : rd
  task automatic cnt(input logic [7:0] c, input logic [15:0] e);
    wr(COUNT_SEL_OFF, c);
    rd(COUNT_LO_OFF, v);
    rd(COUNT_HI_OFF, h);
    chk({h, v}, e);
  endtask : cnt
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  // ==========================================
  // Main sequence
  initial
  begin
    {standby, wr_stb, rd_stb, clear_event, addr, wdata} = '0;
    resetn = 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    rd(RUN_CTRL_OFFSET, v);
    chk(v, 8'he0);
    rd(LOCKSTEP_OFFSET, v);
    chk(v, 8'he0);
    chk({lockstep_out, run_out}, 16'h0000);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    $display("test table done");
    wr(CLEAR_CMD_OFF, 8'h1f);
    cnt(8'h04, 16'h0000);
    wr(LOCKSTEP_OFFSET, 8'h06);
    wr(PRESET_VAL_OFF, 8'h12);
    wr(PRESET_VAL_OFF, 8'h34);
    wr(PRESET_CMD_OFF, 8'h02);
    cnt(8'h02, 16'h1234);
    cnt(8'h00, 16'h0000);
    wr(PRESET_CMD_OFF, 8'h01);
    @(posedge mclk);
    clear_event <= 5'h02;
    @(posedge mclk);
    clear_event <= 5'h00;
    cnt(8'h02, 16'h0000);
    cnt(8'h00, 16'h1234);
    wr(PRESET_CMD_OFF, 8'h04);
    wr(CLEAR_CMD_OFF, 8'h01);
    cnt(8'h00, 16'h0000);
    cnt(8'h01, 16'h1234);
    wr(CLEAR_CMD_OFF, 8'h02);
    cnt(8'h02, 16'h0000);
    $display("test lockstep done");
    wr(RUN_CTRL_OFFSET, 8'h08);
    wr(RUN_CTRL_OFFSET, 8'h00);
    cnt(8'h03, 16'h0002);
    $display("test count done");
    wr(RUN_CTRL_OFFSET, 8'h1f);
    @(posedge mclk);
    standby <= 1'b1;
    @(posedge mclk);
    standby <= 1'b0;
    rd(LOCKSTEP_OFFSET, v);
    chk({v, 3'h0, run_out}, 16'he000);
    wr(RUN_CTRL_OFFSET, 8'h1f);
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
    #1 chk(run_out, 16'h0000);
    $display("test standby done");
    close_out;
  end
endmodule : tb
